// [rtl/spb_pkg.sv]
// Function
// - Counter B event select, bits 7:4, reset 3
// - Pause bit 8 stops counting and halving on both counters; read clear still acts
// - Either counter at max halves both
// - Counters clear on read, ignore writes
// - Bit 0 flags error; write one clears
// - Bit 1 flags further errors while pending
// - Capture only the first error's details
// - Bit 2 marks watchdog-caused error
// - Capture failing haddr
// - Capture failing hwdata
// - Capture failing hrdata
// - Record hmaster in bits 3:0
// - Record hwrite bit 4, hsize 6:5
// - Record htrans 8:7, hburst 11:9
// - Reference divider code maps 1,2,4,5
// - Feedback divider resets to 25; writes load bits 3:2 only, giving 0 to 3
// - Bit 7 selects extra feedback halving
// - Output dividers 16:14, 22:20, reset 3
// - Bit 19 powers down main PLL
// - Processor clock select and divider
// - Bus clock select and divider
// - GPIO inputs read in bits 22:0
// - Counter A event select, bits 3:0
// - Watchdog error only when enabled
package spb_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PERF_CTL = 8'h44;
  localparam logic [7:0] OFS_PERF_A = 8'h48;
  localparam logic [7:0] OFS_PERF_B = 8'h4c;
  localparam logic [7:0] OFS_ERR_STAT = 8'h50;
  localparam logic [7:0] OFS_ERR_ADDR = 8'h54;
  localparam logic [7:0] OFS_ERR_WDATA = 8'h58;
  localparam logic [7:0] OFS_ERR_RDATA = 8'h5c;
  localparam logic [7:0] OFS_ERR_CTRL = 8'h60;
  localparam logic [7:0] OFS_PLL_CTL = 8'h64;
  localparam logic [7:0] OFS_PROC_CLK = 8'h6c;
  localparam logic [7:0] OFS_BUS_CLK = 8'h70;
  localparam logic [7:0] OFS_GPIO_IN = 8'h88;
  localparam logic [7:0] OFS_WDOG_CTL = 8'h3c;
  // Performance control fields
  localparam logic [3:0] PERF_SEL_A_RST = 4'h0;
  localparam logic [3:0] PERF_SEL_B_RST = 4'h3;
  localparam int PERF_PAUSE_BIT = 8;
  // Error status bits
  localparam int ERR_SEEN_BIT = 0;
  localparam int ERR_OVF_BIT = 1;
  localparam int ERR_WDOG_BIT = 2;
  localparam int WDOG_EN_BIT = 2;
  // PLL control fields and reset values
  localparam logic [1:0] PLL_REFDIV_RST = 2'h0;
  localparam logic [4:0] PLL_FBDIV_RST = 5'h19;
  localparam logic [2:0] PLL_OUTDIV_RST = 3'h3;
  localparam int PLL_HALVE_BIT = 7;
  localparam int PLL_PDOWN_BIT = 19;
  localparam int PLL_PROC_LSB = 14;
  localparam int PLL_MEM_LSB = 20;
  // Final clock mux reset values
  localparam logic [1:0] CLK_SEL_RST = 2'h3;
  localparam logic [1:0] CLK_DIV_RST = 2'h0;
  localparam int GPIO_W = 23;
  // Clock source codes of the final mux
  typedef enum logic [1:0] {
    SRC_MEM0 = 2'h0,
    SRC_MEM1 = 2'h1,
    SRC_PROC = 2'h2,
    SRC_REF = 2'h3
  } spb_src_t;
endpackage

// [rtl/spb_clk_mux.sv]
`timescale 1ns/1ps
// One final clock mux and divider control decoder
module spb_clk_mux (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wr,
  input wire logic [3:0] wdata,
  output logic [3:0] field,
  output logic [1:0] src_sel,
  output logic [2:0] div_ratio
);
  import spb_pkg::*;
  logic [1:0] sel_r;
  logic [1:0] div_r;
  logic [1:0] sel_nxt;
  logic [1:0] div_nxt;
  logic [2:0] ratio_w;

  // Codes 0 and 1 both pick the memory output
  function automatic logic [1:0] norm_src(input logic [1:0] s);
    norm_src = (s == SRC_MEM1) ? SRC_MEM0 : s;
  endfunction

  assign sel_nxt = wr ? wdata[1:0] : sel_r;
  assign div_nxt = wr ? wdata[3:2] : div_r;
  // Divide by 1, 2, 4 or 6
  assign ratio_w = (div_r == 2'h0) ? 3'h1 : (div_r == 2'h1) ? 3'h2 :
                   (div_r == 2'h2) ? 3'h4 : 3'h6;

  // Control register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sel_r <= CLK_SEL_RST;
      div_r <= CLK_DIV_RST;
    end else begin
      sel_r <= sel_nxt;
      div_r <= div_nxt;
    end
  end

  assign field = {div_r, sel_r};
  assign src_sel = norm_src(sel_r);
  assign div_ratio = ratio_w;

  sel_reset_a: assert property (@(posedge clock) $rose(rst_b) |-> sel_r == CLK_SEL_RST)
    else $error("Clock select lost reset value");
endmodule // spb_clk_mux

// [rtl/spb_err_cap.sv]
`timescale 1ns/1ps
// First bus error capture with pipelined address phase
module spb_err_cap (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [31:0] haddr,
  input wire logic [3:0] hmaster,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hburst,
  input wire logic hready,
  input wire logic hresp_err,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic wdog_expire,
  input wire logic wdog_en,
  input wire logic clr,
  output logic [2:0] status,
  output logic [31:0] cap_addr,
  output logic [31:0] cap_wdata,
  output logic [31:0] cap_rdata,
  output logic [11:0] cap_ctrl
);
  import spb_pkg::*;
  logic [31:0] ph_addr_r;
  logic [11:0] ph_ctrl_r;
  logic seen_r;
  logic ovf_r;
  logic wd_r;
  logic err_w;
  logic first_w;

  // Address phase is held until hready so data-phase errors see it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ph_addr_r <= 32'h0;
      ph_ctrl_r <= 12'h0;
    end else if (hready) begin
      ph_addr_r <= haddr;
      ph_ctrl_r <= {hburst, htrans, hsize[1:0], hwrite, hmaster};
    end
  end

  assign err_w = hresp_err | (wdog_expire & wdog_en);
  assign first_w = err_w & ~seen_r;

  // Flags; a new error wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      seen_r <= 1'b0;
      ovf_r <= 1'b0;
      wd_r <= 1'b0;
    end else if (err_w) begin
      seen_r <= 1'b1;
      ovf_r <= seen_r & ~clr;
      wd_r <= (first_w | clr) ? ~hresp_err : wd_r;
    end else if (clr) begin
      seen_r <= 1'b0;
      ovf_r <= 1'b0;
      wd_r <= 1'b0;
    end
  end

  // Details latched only for the first pending error
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cap_addr <= 32'h0;
      cap_wdata <= 32'h0;
      cap_rdata <= 32'h0;
      cap_ctrl <= 12'h0;
    end else if (err_w & (~seen_r | clr)) begin
      cap_addr <= ph_addr_r;
      cap_wdata <= hwdata;
      cap_rdata <= hrdata;
      cap_ctrl <= ph_ctrl_r;
    end
  end

  assign status = {wd_r, ovf_r, seen_r};

  first_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    seen_r & ~clr |=> $stable(cap_addr))
    else $error("Capture overwritten while pending");
  ovf_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    seen_r & err_w & ~clr |=> ovf_r)
    else $error("Overflow not flagged");
  wd_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    first_w & ~clr & ~hresp_err |=> wd_r & seen_r)
    else $error("Watchdog cause not flagged");
endmodule // spb_err_cap

// [rtl/spb_regs.sv]
`timescale 1ns/1ps
// Performance, bus error and clock control register bank on AXI4-Lite
module spb_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [15:0] perf_event,
  input wire logic [31:0] haddr,
  input wire logic [3:0] hmaster,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hburst,
  input wire logic hready,
  input wire logic hresp_err,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic wdog_expire,
  input wire logic [spb_pkg::GPIO_W-1:0] gpio_in,
  output logic [2:0] pll_refdiv,
  output logic [4:0] pll_fbdiv,
  output logic pll_extra_feedback_halving,
  output logic [2:0] pll_proc_div,
  output logic [2:0] pll_mem_div,
  output logic main_pll_pdown,
  output logic [1:0] proc_clk_src,
  output logic [2:0] proc_clk_div,
  output logic [1:0] bus_clk_src,
  output logic [2:0] bus_clk_div
);
  import spb_pkg::*;
  // Write and read channel holding registers
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic rresp_err_r;
  logic bresp_err_r;
  // Control registers
  logic [8:0] perf_ctl_r;
  logic [31:0] cnt_a_r;
  logic [31:0] cnt_b_r;
  logic wdog_en_r;
  logic [1:0] pll_ref_r;
  logic [4:0] pll_fb_r;
  logic pll_halve_r;
  logic [2:0] pll_pdiv_r;
  logic [2:0] pll_mdiv_r;
  logic pll_pd_r;
  // Decode and helper wires
  logic wr_go;
  logic rd_go;
  logic wr_full_word;
  logic [31:0] wr_mask;
  logic ev_a;
  logic ev_b;
  logic sat_w;
  logic clr_a;
  logic clr_b;
  logic err_clr;
  logic wr_proc;
  logic wr_bus;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] pll_word;
  logic [31:0] cnt_a_nxt;
  logic [31:0] cnt_b_nxt;
  logic [2:0] err_status;
  logic [31:0] err_addr;
  logic [31:0] err_wdata;
  logic [31:0] err_rdata;
  logic [11:0] err_ctrl;
  logic [3:0] proc_field;
  logic [3:0] bus_field;

  // Address decode used by both read and write paths
  function automatic logic known_ofs(input logic [7:0] a);
    unique case (a)
      OFS_PERF_CTL, OFS_PERF_A, OFS_PERF_B, OFS_ERR_STAT, OFS_ERR_ADDR,
      OFS_ERR_WDATA, OFS_ERR_RDATA, OFS_ERR_CTRL, OFS_PLL_CTL, OFS_PROC_CLK,
      OFS_BUS_CLK, OFS_GPIO_IN, OFS_WDOG_CTL: known_ofs = 1'b1;
      default: known_ofs = 1'b0;
    endcase
  endfunction

  // Bus handshake: each channel taken once, response after both
  assign s_awready = ~aw_full_r & ~bvalid_r;
  assign s_wready = ~w_full_r & ~bvalid_r;
  assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
  assign s_arready = ~rvalid_r;
  assign rd_go = s_arvalid & s_arready;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_err_r ? 2'h2 : 2'h0;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_err_r ? 2'h2 : 2'h0;

  // Byte strobes widened into a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wr_mask[gi*8 +: 8] = {8{w_strb_r[gi]}};
    end
  endgenerate
  assign wr_full_word = &w_strb_r;
  assign wr_hit = wr_go & known_ofs(aw_addr_r);

  // Write channel capture and response
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_err_r <= 1'b0;
    end else begin
      if (s_awvalid & s_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_wvalid & s_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_err_r <= ~known_ofs(aw_addr_r);
      end else if (s_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Low byte strobe needed for the narrow control fields
  assign err_clr = wr_hit & (aw_addr_r == OFS_ERR_STAT) & w_strb_r[0]
                   & w_data_r[ERR_SEEN_BIT];
  assign wr_proc = wr_hit & (aw_addr_r == OFS_PROC_CLK) & w_strb_r[0];
  assign wr_bus = wr_hit & (aw_addr_r == OFS_BUS_CLK) & w_strb_r[0];

  // Writable control registers; partial strobes merge per byte except the PLL word, which needs all four
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      perf_ctl_r <= {1'b0, PERF_SEL_B_RST, PERF_SEL_A_RST};
      wdog_en_r <= 1'b0;
      pll_ref_r <= PLL_REFDIV_RST;
      pll_fb_r <= PLL_FBDIV_RST;
      pll_halve_r <= 1'b0;
      pll_pdiv_r <= PLL_OUTDIV_RST;
      pll_mdiv_r <= PLL_OUTDIV_RST;
      pll_pd_r <= 1'b0;
    end else if (wr_hit) begin
      if (aw_addr_r == OFS_PERF_CTL) begin
        perf_ctl_r <= (perf_ctl_r & ~wr_mask[8:0]) | (w_data_r[8:0] & wr_mask[8:0]);
      end
      if ((aw_addr_r == OFS_WDOG_CTL) & w_strb_r[0]) begin
        wdog_en_r <= w_data_r[WDOG_EN_BIT];
      end
      if ((aw_addr_r == OFS_PLL_CTL) & wr_full_word) begin
        pll_ref_r <= w_data_r[1:0];
        pll_fb_r <= {3'h0, w_data_r[3:2]};
        pll_halve_r <= w_data_r[PLL_HALVE_BIT];
        pll_pdiv_r <= w_data_r[PLL_PROC_LSB +: 3];
        pll_mdiv_r <= w_data_r[PLL_MEM_LSB +: 3];
        pll_pd_r <= w_data_r[PLL_PDOWN_BIT];
      end
    end
  end

  // Performance counters: pause, halving on saturation, read clear
  assign ev_a = perf_event[perf_ctl_r[3:0]];
  assign ev_b = perf_event[perf_ctl_r[7:4]];
  assign sat_w = (&cnt_a_r) | (&cnt_b_r);
  assign clr_a = rd_go & (s_araddr == OFS_PERF_A);
  assign clr_b = rd_go & (s_araddr == OFS_PERF_B);
  assign cnt_a_nxt = clr_a ? 32'h0 : perf_ctl_r[PERF_PAUSE_BIT] ? cnt_a_r :
                     sat_w ? (cnt_a_r >> 1) : cnt_a_r + {31'h0, ev_a};
  assign cnt_b_nxt = clr_b ? 32'h0 : perf_ctl_r[PERF_PAUSE_BIT] ? cnt_b_r :
                     sat_w ? (cnt_b_r >> 1) : cnt_b_r + {31'h0, ev_b};

  // Counter state; writes never reach it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_a_r <= 32'h0;
      cnt_b_r <= 32'h0;
    end else begin
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
    end
  end

  // First bus error capture
  spb_err_cap u_err (
    .clock(clock),
    .rst_b(rst_b),
    .haddr(haddr),
    .hmaster(hmaster),
    .hwrite(hwrite),
    .hsize(hsize),
    .htrans(htrans),
    .hburst(hburst),
    .hready(hready),
    .hresp_err(hresp_err),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .wdog_expire(wdog_expire),
    .wdog_en(wdog_en_r),
    .clr(err_clr),
    .status(err_status),
    .cap_addr(err_addr),
    .cap_wdata(err_wdata),
    .cap_rdata(err_rdata),
    .cap_ctrl(err_ctrl)
  );

  // Processor and bus final clock muxes
  spb_clk_mux u_proc_clk (
    .clock(clock),
    .rst_b(rst_b),
    .wr(wr_proc),
    .wdata(w_data_r[3:0]),
    .field(proc_field),
    .src_sel(proc_clk_src),
    .div_ratio(proc_clk_div)
  );
  spb_clk_mux u_bus_clk (
    .clock(clock),
    .rst_b(rst_b),
    .wr(wr_bus),
    .wdata(w_data_r[3:0]),
    .field(bus_field),
    .src_sel(bus_clk_src),
    .div_ratio(bus_clk_div)
  );

  // Read image of the PLL word; reserved bits 6:4, 13:8, 18:17 and 31:23 read zero
  assign pll_word = {9'h0, pll_mdiv_r, pll_pd_r, 2'h0, pll_pdiv_r, 6'h0,
                     pll_halve_r, 3'h0, pll_fb_r[1:0], pll_ref_r};

  // Read data selection
  assign rd_hit = known_ofs(s_araddr);
  always_comb begin
    unique case (s_araddr)
      OFS_PERF_CTL: rd_mux = {23'h0, perf_ctl_r};
      OFS_PERF_A: rd_mux = cnt_a_r;
      OFS_PERF_B: rd_mux = cnt_b_r;
      OFS_ERR_STAT: rd_mux = {29'h0, err_status};
      OFS_ERR_ADDR: rd_mux = err_addr;
      OFS_ERR_WDATA: rd_mux = err_wdata;
      OFS_ERR_RDATA: rd_mux = err_rdata;
      OFS_ERR_CTRL: rd_mux = {20'h0, err_ctrl};
      OFS_PLL_CTL: rd_mux = pll_word;
      OFS_PROC_CLK: rd_mux = {28'h0, proc_field};
      OFS_BUS_CLK: rd_mux = {28'h0, bus_field};
      OFS_GPIO_IN: rd_mux = {9'h0, gpio_in};
      OFS_WDOG_CTL: rd_mux = {29'h0, wdog_en_r, 2'h0};
      default: rd_mux = 32'h0;
    endcase
  end

  // Read response register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_err_r <= 1'b0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_err_r <= ~rd_hit;
    end else if (s_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // PLL control decode; refdiv code 3 means 5
  assign pll_refdiv = (pll_ref_r == 2'h3) ? 3'h5 :
                      (pll_ref_r == 2'h2) ? 3'h4 : {1'b0, pll_ref_r} + 3'h1;
  assign pll_fbdiv = pll_fb_r;
  assign pll_extra_feedback_halving = pll_halve_r;
  assign pll_proc_div = pll_pdiv_r;
  assign pll_mem_div = pll_mdiv_r;
  assign main_pll_pdown = pll_pd_r;

  pause_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    perf_ctl_r[PERF_PAUSE_BIT] & ~clr_a |=> $stable(cnt_a_r))
    else $error("Counter A moved while paused");
  halve_both_a: assert property (@(posedge clock) disable iff (!rst_b)
    sat_w & ~perf_ctl_r[PERF_PAUSE_BIT] & ~clr_b |=> cnt_b_r == $past(cnt_b_r) >> 1)
    else $error("Counter B not halved");
  read_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
    clr_a |=> rvalid_r && rdata_r == $past(cnt_a_r) && cnt_a_r == 32'h0)
    else $error("Counter A not read and cleared");

  // Counter B takes the same read-and-clear path as counter A
  sequence rd_b_s;
    clr_b;
  endsequence
  read_clear_b_a: assert property (@(posedge clock) disable iff (!rst_b)
    rd_b_s |=> rdata_r == $past(cnt_b_r) && cnt_b_r == 32'h0)
    else $error("Counter B not read and cleared");

  err_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
    err_clr & ~hresp_err & ~wdog_expire |=> err_status == 3'h0)
    else $error("Error status not cleared");
  pll_reset_a: assert property (@(posedge clock) $rose(rst_b) |->
    pll_fb_r == PLL_FBDIV_RST && pll_pdiv_r == PLL_OUTDIV_RST && !pll_pd_r)
    else $error("PLL control reset wrong");

  // Partial strobes leave the PLL word alone, so only full-word writes are checked
  sequence pll_word_wr_s;
    wr_hit && aw_addr_r == OFS_PLL_CTL && wr_full_word;
  endsequence
  pll_pdown_a: assert property (@(posedge clock) disable iff (!rst_b)
    pll_word_wr_s |=> main_pll_pdown == $past(w_data_r[PLL_PDOWN_BIT]))
    else $error("PLL power down not written");

  gpio_read_a: assert property (@(posedge clock) disable iff (!rst_b)
    rd_go && s_araddr == OFS_GPIO_IN |=> rdata_r == {9'h0, $past(gpio_in)})
    else $error("GPIO sample wrong");
endmodule // spb_regs

// [verif/spb_ahb_model.sv]
`timescale 1ns/1ps
// Bus master stand-in: one address phase, then one data phase with optional error
module spb_ahb_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic go,
  input wire logic err,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdat,
  input wire logic [31:0] rdat,
  input wire logic [12:0] ctrl,
  output logic [31:0] haddr,
  output logic [3:0] hmaster,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [1:0] htrans,
  output logic [2:0] hburst,
  output logic hready,
  output logic hresp_err,
  output logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic done
);
  logic [1:0] st_r; // Transfer step
  // Idle address and data lines toggle so a stale sample never looks like a match
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r <= 2'h0;
      haddr <= 32'h0;
      hwdata <= 32'h0;
      hrdata <= 32'h0;
      {hmaster, hwrite, hsize, htrans, hburst} <= 13'h0;
      hready <= 1'h1;
      hresp_err <= 1'h0;
      done <= 1'h0;
    end else begin
      hready <= 1'h1;
      hresp_err <= 1'h0;
      done <= 1'h0;
      haddr <= ~haddr;
      hwdata <= ~hwdata;
      hrdata <= ~hrdata;
      {hmaster, hwrite, hsize, htrans, hburst} <= 13'h0;
      case (st_r)
        // Address phase, sampled with hready high
        2'h0: if (go) begin
          st_r <= 2'h1;
          haddr <= addr;
          {hmaster, hwrite, hsize, htrans, hburst} <= ctrl;
        end
        // Data phase; address lines already moved on
        2'h1: begin
          st_r <= 2'h2;
          hready <= 1'h0;
          hresp_err <= err;
          hwdata <= wdat;
          hrdata <= rdat;
        end
        default: begin
          st_r <= 2'h0;
          done <= 1'h1;
        end
      endcase
    end
  end
endmodule // spb_ahb_model

// [verif/tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the register bank
module tb;
  import spb_pkg::*;
  localparam logic [2:0] RT [4] = '{3'h1, 3'h2, 3'h4, 3'h6}; // Final divide ratios
  localparam logic [2:0] RD [4] = '{3'h1, 3'h2, 3'h4, 3'h5}; // Reference ratios
  logic clock = 1'h0, rst_b = 1'h0;
  logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic [31:0] s_wdata = 32'h0, m_addr = 32'h0, m_wdat = 32'h0, m_rdat = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, done;
  logic [1:0] s_bresp, s_rresp, htrans, proc_clk_src, bus_clk_src;
  logic [31:0] s_rdata, haddr, hwdata, hrdata;
  logic [15:0] perf_event = 16'h0;
  logic wdog_expire = 1'h0, go = 1'h0, err = 1'h0;
  logic [12:0] m_ctrl = 13'h0;
  logic [3:0] hmaster;
  logic hwrite, hready, hresp_err, pll_extra_feedback_halving, main_pll_pdown;
  logic [2:0] hsize, hburst, pll_refdiv, pll_proc_div, pll_mem_div, proc_clk_div, bus_clk_div;
  logic [GPIO_W-1:0] gpio_in = 23'h0;
  logic [4:0] pll_fbdiv;
  int bad_count = 0, comparisons = 0, cyc = 0;

  spb_regs u_spb_regs (.clock, .rst_b, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .perf_event, .haddr, .hmaster, .hwrite, .hsize,
    .htrans, .hburst, .hready, .hresp_err, .hwdata, .hrdata, .wdog_expire, .gpio_in,
    .pll_refdiv, .pll_fbdiv, .pll_extra_feedback_halving, .pll_proc_div, .pll_mem_div,
    .main_pll_pdown, .proc_clk_src, .proc_clk_div, .bus_clk_src, .bus_clk_div);
  spb_ahb_model u_spb_ahb_model (.clock, .rst_b, .go, .err, .addr(m_addr), .wdat(m_wdat),
    .rdat(m_rdat), .ctrl(m_ctrl), .haddr, .hmaster, .hwrite, .hsize, .htrans, .hburst,
    .hready, .hresp_err, .hwdata, .hrdata, .done);

  // Free-running 10 MHz clock
  initial forever #50 clock = ~clock;

  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw = 1'b1;
    bit w = 1'b1;
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_awready === 1'h1) begin
        aw = 1'b0;
        s_awvalid <= 1'h0;
      end
      if (w && s_wready === 1'h1) begin
        w = 1'b0;
        s_wvalid <= 1'h0;
      end
    end
    do @(posedge clock); while (s_bvalid !== 1'h1);
    s_bready <= 1'h0;
    chk("bresp", er, s_bresp);
  endtask

  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
      input string nm);
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(posedge clock); while (s_arready !== 1'h1);
    s_arvalid <= 1'h0;
    do @(posedge clock); while (s_rvalid !== 1'h1);
    s_rready <= 1'h0;
    chk(nm, e, s_rdata);
    chk("rresp", er, s_rresp);
  endtask

  // One bus transfer through the master model
  task automatic ahb(input logic e, input logic [31:0] a, input logic [12:0] c);
    @(posedge clock);
    err <= e;
    m_addr <= a;
    m_wdat <= a ^ 32'ha5a5_0f0f;
    m_rdat <= a ^ 32'h3c3c_c3c3;
    m_ctrl <= c;
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    do @(posedge clock); while (done !== 1'h1);
    repeat (2) @(posedge clock);
  endtask

  task automatic t_reset();
    rd(OFS_PERF_CTL, 32'h30, 2'h0, "perf_ctl");
    rd(OFS_PERF_A, 32'h0, 2'h0, "perf_a");
    rd(OFS_ERR_STAT, 32'h0, 2'h0, "err_stat");
    rd(OFS_PLL_CTL, 32'h0030_c004, 2'h0, "pll_ctl");
    chk("pll_fbdiv", 32'h19, pll_fbdiv);
    chk("pll_refdiv", 32'h1, pll_refdiv);
    rd(OFS_PROC_CLK, 32'h3, 2'h0, "proc_clk");
    rd(OFS_BUS_CLK, 32'h3, 2'h0, "bus_clk");
    rd(8'h80, 32'h0, 2'h2, "unmapped");
    wr(8'h80, 32'hffff_ffff, 2'h2);
  endtask

  // Every source and divider code on both final muxes; ends on the reference divided by 6
  task automatic t_clk();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      wr(OFS_PROC_CLK, {28'h0, v}, 2'h0);
      wr(OFS_BUS_CLK, {28'h0, v}, 2'h0);
      chk("proc_src", (v[1:0] == 2'h1) ? 2'h0 : v[1:0], proc_clk_src);
      chk("proc_div", RT[v[3:2]], proc_clk_div);
      chk("bus_src", (v[1:0] == 2'h1) ? 2'h0 : v[1:0], bus_clk_src);
      chk("bus_div", RT[v[3:2]], bus_clk_div);
      rd(OFS_BUS_CLK, {28'h0, v}, 2'h0, "bus_clk");
    end
  endtask

  // Power down is set only while both muxes run from the reference
  task automatic t_pll();
    for (int k = 0; k < 4; k++) begin
      wr(OFS_PLL_CTL, 32'h0009_0088 | k, 2'h0);
      chk("pll_refdiv", RD[k], pll_refdiv);
      chk("pll_halve", 32'h1, pll_extra_feedback_halving);
      chk("pll_pdown", 32'h1, main_pll_pdown);
      chk("pll_proc", 32'h4, pll_proc_div);
      chk("pll_mem", 32'h0, pll_mem_div);
      rd(OFS_PLL_CTL, 32'h0009_0088 | k, 2'h0, "pll_ctl");
    end
    wr(OFS_PLL_CTL, 32'h0030_c004, 2'h0);
    chk("pll_pdown", 32'h0, main_pll_pdown);
    chk("pll_mem", 32'h3, pll_mem_div);
  endtask

  // Event pattern: both events 3 cycles, first only 2, the rest 2
  task automatic events();
    @(posedge clock);
    perf_event <= 16'h0088;
    repeat (3) @(posedge clock);
    perf_event <= 16'h0008;
    repeat (2) @(posedge clock);
    perf_event <= 16'hff77;
    repeat (2) @(posedge clock);
    perf_event <= 16'h0;
    repeat (2) @(posedge clock);
  endtask

  task automatic t_perf();
    wr(OFS_PERF_CTL, 32'h73, 2'h0);
    events();
    rd(OFS_PERF_A, 32'h5, 2'h0, "perf_a");
    rd(OFS_PERF_B, 32'h3, 2'h0, "perf_b");
    rd(OFS_PERF_A, 32'h0, 2'h0, "perf_a_clr");
    wr(OFS_PERF_B, 32'hffff_ffff, 2'h0);
    rd(OFS_PERF_B, 32'h0, 2'h0, "perf_b_wr");
    wr(OFS_PERF_CTL, 32'h173, 2'h0);
    events();
    rd(OFS_PERF_CTL, 32'h173, 2'h0, "perf_ctl");
    rd(OFS_PERF_A, 32'h0, 2'h0, "perf_a_hold");
    rd(OFS_PERF_B, 32'h0, 2'h0, "perf_b_hold");
  endtask

  task automatic wdog();
    @(posedge clock);
    wdog_expire <= 1'h1;
    @(posedge clock);
    wdog_expire <= 1'h0;
    repeat (2) @(posedge clock);
  endtask

  task automatic t_err();
    wr(OFS_WDOG_CTL, 32'h0, 2'h0);
    wdog();
    ahb(1'h0, 32'h0000_1000, 13'h0b53);
    rd(OFS_ERR_STAT, 32'h0, 2'h0, "stat_none");
    ahb(1'h1, 32'h1234_5678, {4'h5, 1'h1, 3'h2, 2'h2, 3'h3});
    rd(OFS_ERR_STAT, 32'h1, 2'h0, "stat_first");
    rd(OFS_ERR_ADDR, 32'h1234_5678, 2'h0, "cap_addr");
    rd(OFS_ERR_WDATA, 32'hb791_5977, 2'h0, "cap_wdata");
    rd(OFS_ERR_RDATA, 32'h2e08_95bb, 2'h0, "cap_rdata");
    rd(OFS_ERR_CTRL, 32'h755, 2'h0, "cap_ctrl");
    ahb(1'h1, 32'h0bad_0004, {4'h1, 1'h0, 3'h0, 2'h3, 3'h1});
    rd(OFS_ERR_STAT, 32'h3, 2'h0, "stat_ovf");
    rd(OFS_ERR_ADDR, 32'h1234_5678, 2'h0, "cap_keep");
    rd(OFS_ERR_CTRL, 32'h755, 2'h0, "ctrl_keep");
    wr(OFS_ERR_STAT, 32'h6, 2'h0);
    rd(OFS_ERR_STAT, 32'h3, 2'h0, "stat_w0");
    wr(OFS_ERR_STAT, 32'h1, 2'h0);
    rd(OFS_ERR_STAT, 32'h0, 2'h0, "stat_clr");
    ahb(1'h1, 32'h0000_0040, {4'h2, 1'h0, 3'h1, 2'h3, 3'h2});
    rd(OFS_ERR_CTRL, 32'h5a2, 2'h0, "ctrl_new");
    rd(OFS_ERR_STAT, 32'h1, 2'h0, "stat_hresp");
    wr(OFS_ERR_STAT, 32'h1, 2'h0);
    wr(OFS_WDOG_CTL, 32'h4, 2'h0);
    wdog();
    rd(OFS_ERR_STAT, 32'h5, 2'h0, "stat_wdog");
    rd(OFS_WDOG_CTL, 32'h4, 2'h0, "wdog_ctl");
  endtask

  // Live input levels, no reset involved
  task automatic t_gpio();
    @(posedge clock);
    gpio_in <= 23'h5a_3c96;
    rd(OFS_GPIO_IN, 32'h005a_3c96, 2'h0, "gpio_in");
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'h1;
    t_reset();
    t_clk();
    t_pll();
    t_perf();
    t_err();
    t_gpio();
    results();
  end
endmodule // tb
